// [rtl/djs_pkg.sv]
// Package: constants and carriers for the start/jog/stop sequencer
package djs_pkg;
    // APB register byte offsets
    localparam logic [7:0] OFS_RUN_REF   = 8'h00;
    localparam logic [7:0] OFS_JOG_SPD1  = 8'h04;
    localparam logic [7:0] OFS_JOG_SPD2  = 8'h08;
    localparam logic [7:0] OFS_SLK_SPD1  = 8'h0C;
    localparam logic [7:0] OFS_SLK_SPD2  = 8'h10;
    localparam logic [7:0] OFS_CRAWL_SPD = 8'h14;
    localparam logic [7:0] OFS_RUN_STEP  = 8'h18;
    localparam logic [7:0] OFS_STOP_STEP = 8'h1C;
    localparam logic [7:0] OFS_JOG_STEP  = 8'h20;
    localparam logic [7:0] OFS_DROP_MS   = 8'h24;
    localparam logic [7:0] OFS_STATUS    = 8'h28;
    localparam int         NCFG          = 10;
    // Config word indexes (offset / 4)
    localparam int IX_RUN_REF   = 0;
    localparam int IX_JOG_SPD1  = 1;
    localparam int IX_JOG_SPD2  = 2;
    localparam int IX_SLK_SPD1  = 3;
    localparam int IX_SLK_SPD2  = 4;
    localparam int IX_CRAWL_SPD = 5;
    localparam int IX_RUN_STEP  = 6;
    localparam int IX_STOP_STEP = 7;
    localparam int IX_JOG_STEP  = 8;
    localparam int IX_DROP_MS   = 9;
    // Reset values, index 0 first
    localparam logic [15:0] RST_RUN_REF   = 16'h8000;
    localparam logic [15:0] RST_JOG_SPD1  = 16'h0800;
    localparam logic [15:0] RST_JOG_SPD2  = 16'h1000;
    localparam logic [15:0] RST_SLK_SPD1  = 16'h0400;
    localparam logic [15:0] RST_SLK_SPD2  = 16'h0C00;
    localparam logic [15:0] RST_CRAWL_SPD = 16'h0600;
    localparam logic [15:0] RST_RUN_STEP  = 16'h0010;
    localparam logic [15:0] RST_STOP_STEP = 16'h0010;
    localparam logic [15:0] RST_JOG_STEP  = 16'h0020;
    localparam logic [15:0] RST_DROP_MS   = 16'h03E8;
    // Status word field positions
    localparam int ST_DEMAND_LSB = 0;
    localparam int ST_CONT_BIT   = 16;
    localparam int ST_LOOPS_BIT  = 17;
    localparam int ST_STATE_LSB  = 20;
    // Ramp time base: one tick per millisecond at 40 ns
    localparam int CLK_NS  = 40;
    localparam int TICK_NS = 1000000;
    localparam int TICK_CYC = TICK_NS / CLK_NS;

    typedef enum logic [2:0] {
        ST_IDLE, ST_RUN, ST_CRAWL, ST_SLACK,
        ST_JOG, ST_JOG_DOWN, ST_HOLD, ST_STOP
    } djs_state_e;

    // Operator and plant inputs, carried together
    typedef struct packed {
        logic run;
        logic jog;
        logic start;
        logic cstop;
        logic sel;
        logic zero;
        logic alarm;
        logic supply_low;
    } djs_in_s;
endpackage

// [rtl/djs_sequencer.sv]
// Start/jog/stop sequencer with ramp generator and APB registers
//
// Notes on behaviour
// - Jog high, start low: run jog speed
// - Jog released: ramp to zero, jog ramp
// - Jog speed chosen by speed select level
// - Select low speed one, high speed two
// - Start needs no alarm, cstop, run, !jog
// - Start low: ramped stop at stop ramp
// - Zero speed after stop drops contactor
// - Two jog speeds, programmable dropout delay
// - Jog rising while running: slack take-up
// - Select high, start rising: crawl speed
// - Crawl accelerates run ramp, stops stop ramp
// - Coast stop low: contactor open, no run
// - Coast stop falling: contactor drops, coast
// - Control supply low: orderly ramped shutdown
// - Run low inhibits all control loops
// - Run low while stopping drops contactor
`timescale 1ns/1ps
module djs_sequencer #(
    parameter int TICK_CYCLES = djs_pkg::TICK_CYC // Cycles per ms tick
) (
    input  wire logic        pclk,                // 25 MHz clock
    input  wire logic        presetn,             // Async reset, low
    input  wire logic        psel,                // APB select
    input  wire logic        penable,             // APB enable
    input  wire logic        pwrite,              // APB direction
    input  wire logic [7:0]  paddr,               // APB byte address
    input  wire logic [31:0] pwdata,              // APB write data
    output logic      [31:0] prdata,              // APB read data
    output logic             pready,              // APB ready
    output logic             pslverr,             // APB error
    input  wire logic        run_in,              // Run enable pin
    input  wire logic        jog_in,              // Jog pin
    input  wire logic        start_in,            // Start pin
    input  wire logic        cstop_in,            // Coast stop pin
    input  wire logic        jog_speed_select_in, // Speed select pin
    input  wire logic        zero_speed_in,       // Zero speed detect
    input  wire logic        alarm_in,            // Any alarm active
    input  wire logic        supply_low_in,       // Control supply low
    output logic             contactor_out,       // Contactor relay
    output logic             loops_enable_out,    // Control loops on
    output logic      [15:0] speed_demand_out     // Ramped demand
);
    // Pin synchroniser, two stages
    djs_pkg::djs_in_s       pin_raw;
    djs_pkg::djs_in_s       sync1_reg;
    djs_pkg::djs_in_s       sync2_reg;
    djs_pkg::djs_in_s       prev_reg;
    djs_pkg::djs_state_e    state_reg;
    djs_pkg::djs_state_e    state_next;
    logic [15:0]            cfg_reg [djs_pkg::NCFG];
    logic [15:0]            demand_reg;
    logic [15:0]            demand_next;
    logic [15:0]            hold_reg;
    logic [15:0]            hold_next;
    logic [14:0]            div_reg;
    logic                   tick_reg;
    logic                   cont_reg;
    logic                   loops_reg;
    logic [31:0]            rdata_reg;
    logic                   ready_reg;
    logic                   err_reg;

    assign pin_raw = '{run: run_in, jog: jog_in, start: start_in,
                       cstop: cstop_in, sel: jog_speed_select_in,
                       zero: zero_speed_in, alarm: alarm_in,
                       supply_low: supply_low_in};

    // First stage feeds only the second stage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            prev_reg  <= '0;
        end else begin
            sync1_reg <= pin_raw;
            sync2_reg <= sync1_reg;
            prev_reg  <= sync2_reg;
        end
    end

    // Edge and qualification terms
    wire logic run_q    = sync2_reg.run;
    wire logic jog_q    = sync2_reg.jog;
    wire logic start_q  = sync2_reg.start;
    wire logic cstop_q  = sync2_reg.cstop;
    wire logic sel_q    = sync2_reg.sel;
    wire logic zero_q   = sync2_reg.zero;
    wire logic jog_rise = jog_q & ~prev_reg.jog;
    wire logic st_rise  = start_q & ~prev_reg.start;
    // Coast stop or run low overrides everything, no ramp
    wire logic trip     = ~cstop_q | ~run_q;
    wire logic may_go   = ~sync2_reg.alarm & cstop_q & run_q
                          & ~sync2_reg.supply_low;

    // Millisecond tick divider; ramps and delays step on it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_reg  <= '0;
            tick_reg <= 1'b0;
        end else if (div_reg == 15'(TICK_CYCLES - 1)) begin
            div_reg  <= '0;
            tick_reg <= 1'b1;
        end else begin
            div_reg  <= div_reg + 15'h0001;
            tick_reg <= 1'b0;
        end
    end

    // Speed pair choice by select level, low picks first
    function automatic logic [15:0] pick(input logic s,
                                         input logic [15:0] a,
                                         input logic [15:0] b);
        pick = s ? b : a;
    endfunction

    wire logic [15:0] jog_spd = pick(sel_q,
        cfg_reg[djs_pkg::IX_JOG_SPD1],
        cfg_reg[djs_pkg::IX_JOG_SPD2]);
    wire logic [15:0] slk_spd = pick(sel_q,
        cfg_reg[djs_pkg::IX_SLK_SPD1],
        cfg_reg[djs_pkg::IX_SLK_SPD2]);

    // Ramp target per state
    logic [15:0] target;
    logic [15:0] step;
    always_comb begin
        target = 16'h0000;
        step   = cfg_reg[djs_pkg::IX_STOP_STEP];
        case (state_reg)
            djs_pkg::ST_RUN: begin
                target = cfg_reg[djs_pkg::IX_RUN_REF];
                step   = cfg_reg[djs_pkg::IX_RUN_STEP];
            end
            djs_pkg::ST_CRAWL: begin
                target = cfg_reg[djs_pkg::IX_CRAWL_SPD];
                step   = (demand_reg > target)
                         ? cfg_reg[djs_pkg::IX_STOP_STEP]
                         : cfg_reg[djs_pkg::IX_RUN_STEP];
            end
            djs_pkg::ST_SLACK: begin
                target = slk_spd;
                step   = cfg_reg[djs_pkg::IX_JOG_STEP];
            end
            djs_pkg::ST_JOG: begin
                target = jog_spd;
                step   = cfg_reg[djs_pkg::IX_JOG_STEP];
            end
            djs_pkg::ST_JOG_DOWN: begin
                step   = cfg_reg[djs_pkg::IX_JOG_STEP];
            end
            djs_pkg::ST_STOP: begin
                step   = cfg_reg[djs_pkg::IX_STOP_STEP];
            end
            default: begin
                target = 16'h0000;
            end
        endcase
    end

    // Ramp: move demand toward target by step per tick, no overshoot
    wire logic [16:0] up_sum = {1'b0, demand_reg} + {1'b0, step};
    wire logic [16:0] dn_dif = {1'b0, demand_reg} - {1'b0, step};
    always_comb begin
        demand_next = demand_reg;
        if (trip || state_next == djs_pkg::ST_IDLE) begin
            demand_next = 16'h0000;
        end else if (tick_reg && demand_reg < target) begin
            demand_next = (up_sum[16] || up_sum[15:0] > target)
                          ? target : up_sum[15:0];
        end else if (tick_reg && demand_reg > target) begin
            demand_next = (dn_dif[16] || dn_dif[15:0] < target)
                          ? target : dn_dif[15:0];
        end
    end

    wire logic at_zero = (demand_reg == 16'h0000) & zero_q;

    // Sequencer next state
    always_comb begin
        state_next = state_reg;
        hold_next  = hold_reg;
        case (state_reg)
            djs_pkg::ST_IDLE: begin
                if (may_go && start_q && !jog_q) begin
                    // Crawl needs a fresh start edge with select high
                    state_next = (sel_q && st_rise)
                                 ? djs_pkg::ST_CRAWL
                                 : djs_pkg::ST_RUN;
                end else if (may_go && jog_q && !start_q) begin
                    state_next = djs_pkg::ST_JOG;
                end
            end
            djs_pkg::ST_RUN: begin
                if (!start_q) begin
                    state_next = djs_pkg::ST_STOP;
                end else if (jog_rise) begin
                    state_next = djs_pkg::ST_SLACK;
                end
            end
            djs_pkg::ST_SLACK: begin
                if (!start_q) begin
                    state_next = djs_pkg::ST_STOP;
                end else if (!jog_q) begin
                    state_next = djs_pkg::ST_RUN;
                end
            end
            djs_pkg::ST_CRAWL: begin
                if (!start_q) begin
                    state_next = djs_pkg::ST_STOP;
                end
            end
            djs_pkg::ST_JOG: begin
                if (!jog_q || start_q) begin
                    state_next = djs_pkg::ST_JOG_DOWN;
                end
            end
            djs_pkg::ST_JOG_DOWN: begin
                if (jog_q && !start_q) begin
                    state_next = djs_pkg::ST_JOG;
                end else if (at_zero) begin
                    state_next = djs_pkg::ST_HOLD;
                    hold_next  = cfg_reg[djs_pkg::IX_DROP_MS];
                end
            end
            djs_pkg::ST_HOLD: begin
                if (jog_q && !start_q) begin
                    state_next = djs_pkg::ST_JOG;
                end else if (hold_reg == 16'h0000) begin
                    state_next = djs_pkg::ST_IDLE;
                end else if (tick_reg) begin
                    hold_next = hold_reg - 16'h0001;
                end
            end
            djs_pkg::ST_STOP: begin
                if (at_zero) begin
                    state_next = djs_pkg::ST_IDLE;
                end
            end
            default: begin
                state_next = djs_pkg::ST_IDLE;
            end
        endcase
        // Supply loss forces an orderly ramp down
        if (sync2_reg.supply_low && state_reg != djs_pkg::ST_IDLE
            && state_reg != djs_pkg::ST_HOLD) begin
            state_next = at_zero ? djs_pkg::ST_IDLE
                                 : djs_pkg::ST_STOP;
        end
        // Trip overrides any stop phase or hold delay at once
        if (trip) begin
            state_next = djs_pkg::ST_IDLE;
        end
    end

    // Sequencer and outputs; contactor follows next state so it
    // drops one edge after the trip is seen, far inside 100 ms
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg  <= djs_pkg::ST_IDLE;
            demand_reg <= '0;
            hold_reg   <= '0;
            cont_reg   <= 1'b0;
            loops_reg  <= 1'b0;
        end else begin
            state_reg  <= state_next;
            demand_reg <= demand_next;
            hold_reg   <= hold_next;
            cont_reg   <= (state_next != djs_pkg::ST_IDLE);
            loops_reg  <= (state_next != djs_pkg::ST_IDLE)
                          & ~trip;
        end
    end

    // APB decode; one wait-free access cycle after setup
    wire logic       setup   = psel & ~penable;
    wire logic       wr_ok   = psel & penable & pwrite & ready_reg;
    wire logic [5:0] idx     = paddr[7:2];
    wire logic       cfg_hit = (paddr[1:0] == 2'b00)
                               && (idx < 6'(djs_pkg::NCFG));
    wire logic       st_hit  = (paddr == djs_pkg::OFS_STATUS);
    wire logic       miss    = ~cfg_hit & ~(st_hit & ~pwrite);
    wire logic [31:0] status_w =
        (32'(demand_reg) << djs_pkg::ST_DEMAND_LSB)
        | (32'(cont_reg) << djs_pkg::ST_CONT_BIT)
        | (32'(loops_reg) << djs_pkg::ST_LOOPS_BIT)
        | (32'(state_reg) << djs_pkg::ST_STATE_LSB);
    wire logic [31:0] rd_w   = cfg_hit ? 32'(cfg_reg[idx[3:0]])
                               : st_hit ? status_w : 32'h00000000;

    // Bus answer flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ready_reg <= 1'b0;
            err_reg   <= 1'b0;
            rdata_reg <= '0;
        end else begin
            ready_reg <= setup;
            err_reg   <= setup & miss;
            rdata_reg <= (setup & ~pwrite) ? rd_w : 32'h00000000;
        end
    end

    // Config storage; low 16 bits kept, upper bits read zero
    localparam logic [15:0] CFG_RST [djs_pkg::NCFG] = '{
        djs_pkg::RST_RUN_REF,  djs_pkg::RST_JOG_SPD1,
        djs_pkg::RST_JOG_SPD2, djs_pkg::RST_SLK_SPD1,
        djs_pkg::RST_SLK_SPD2, djs_pkg::RST_CRAWL_SPD,
        djs_pkg::RST_RUN_STEP, djs_pkg::RST_STOP_STEP,
        djs_pkg::RST_JOG_STEP, djs_pkg::RST_DROP_MS};
    for (genvar i = 0; i < djs_pkg::NCFG; i++) begin : g_cfg
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                cfg_reg[i] <= CFG_RST[i];
            end else if (wr_ok && cfg_hit && idx == 6'(i)) begin
                cfg_reg[i] <= pwdata[15:0];
            end
        end
    end

    assign prdata           = rdata_reg;
    assign pready           = ready_reg;
    assign pslverr          = err_reg;
    assign contactor_out    = cont_reg;
    assign loops_enable_out = loops_reg;
    assign speed_demand_out = demand_reg;
endmodule

// [sim/djs_plant.sv]
// Far-side model: operator switches, relay latching and motor rest sensing
`timescale 1ns/1ps
module djs_plant #(
    parameter int CST_MIN = 500 // Coast stop lead before start, cycles
) (
    input  wire logic        pclk,         // Clock
    input  wire logic        presetn,      // Reset, active low
    input  wire logic        start_cmd,    // Operator start switch
    input  wire logic        cstop_cmd,    // Operator coast stop switch
    input  wire logic [15:0] speed_demand, // Demand from the drive
    output logic             start_in,     // Maintained start level
    output logic             cstop_in,     // Coast stop relay level
    output logic             zero_speed_in // Motor at rest
);
    int unsigned lead_cnt;
    logic [3:0]  rest_sr;

    // Coast stop wiring goes straight through
    assign cstop_in = cstop_cmd;
    // Motor lags the demand by a few cycles before it reads as stopped
    assign zero_speed_in = &rest_sr;

    // Start is released only after coast stop has led it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lead_cnt <= 0;
            start_in <= 1'b0;
            rest_sr  <= 4'hF;
        end else begin
            if (!cstop_cmd) begin
                lead_cnt <= 0;
            end else if (lead_cnt < CST_MIN) begin
                lead_cnt <= lead_cnt + 1;
            end
            // Latched as a level, never a pulse
            start_in <= start_cmd && cstop_cmd
                        && (start_in || lead_cnt >= CST_MIN);
            rest_sr  <= {rest_sr[2:0], speed_demand == 16'h0000};
        end
    end
endmodule

// [sim/djs_sequencer_chk.sv]
// Checker: bus timing and safety relations at the sequencer ports
`timescale 1ns/1ps
module djs_sequencer_chk (
    input wire logic        pclk,             // Clock
    input wire logic        presetn,          // Reset, active low
    input wire logic        psel,             // APB select
    input wire logic        penable,          // APB enable
    input wire logic        pready,           // APB ready
    input wire logic        run_in,           // Run enable
    input wire logic        cstop_in,         // Coast stop
    input wire logic        zero_speed_in,    // Motor at rest
    input wire logic        alarm_in,         // Alarm active
    input wire logic        supply_low_in,    // Supply low
    input wire logic        contactor_out,    // Contactor
    input wire logic        loops_enable_out, // Loops on
    input wire logic [15:0] speed_demand_out  // Demand
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Coast stop falling while energised
    sequence s_coast;
        $fell(cstop_in) ##0 contactor_out;
    endsequence
    sequence s_dropped;
        !contactor_out && speed_demand_out == 16'h0000;
    endsequence

    property p_apb_answer;
        psel && !penable |=> pready;
    endproperty
    a_apb_answer: assert property (p_apb_answer) else $error("no ready");
    property p_apb_pulse;
        pready |=> !pready;
    endproperty
    a_apb_pulse: assert property (p_apb_pulse) else $error("ready held");
    property p_coast;
        s_coast |-> ##[1:8] s_dropped;
    endproperty
    a_coast: assert property (p_coast) else $error("coast late");
    property p_cstop_hold;
        !cstop_in [*6] |-> !contactor_out;
    endproperty
    a_cstop_hold: assert property (p_cstop_hold)
        else $error("contactor with coast stop low");
    property p_run_inhibit;
        !run_in [*6] |-> !loops_enable_out;
    endproperty
    a_run_inhibit: assert property (p_run_inhibit)
        else $error("loops on with run low");
    property p_run_drop;
        $fell(run_in) |-> ##[1:8] !contactor_out;
    endproperty
    a_run_drop: assert property (p_run_drop) else $error("run drop");
    property p_start_gate;
        $rose(contactor_out) |->
            run_in && cstop_in && !alarm_in && !supply_low_in;
    endproperty
    a_start_gate: assert property (p_start_gate)
        else $error("start not gated");
    property p_stop_zero;
        $fell(contactor_out) && cstop_in && run_in |-> zero_speed_in;
    endproperty
    a_stop_zero: assert property (p_stop_zero)
        else $error("drop before rest");
    property p_off_zero;
        !contactor_out |-> speed_demand_out == 16'h0000;
    endproperty
    a_off_zero: assert property (p_off_zero)
        else $error("demand with contactor open");
endmodule

bind djs_sequencer djs_sequencer_chk djs_sequencer_chk_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pready(pready), .run_in(run_in), .cstop_in(cstop_in),
    .zero_speed_in(zero_speed_in), .alarm_in(alarm_in),
    .supply_low_in(supply_low_in), .contactor_out(contactor_out),
    .loops_enable_out(loops_enable_out),
    .speed_demand_out(speed_demand_out));

// [sim/djs_sequencer_test.sv]
// Self-checking bench for the start/jog/stop sequencer
`timescale 1ns/1ps
module djs_sequencer_test;
    localparam int TICK = 10; // Short ms tick keeps ramps brief
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        run_in, jog_in, start_cmd, cstop_cmd, sel_in, alarm_in;
    logic        low_in, start_in, cstop_in, zero_in, cont, loops, err;
    logic [15:0] dem;
    int          n_errors, checks;

    djs_sequencer #(.TICK_CYCLES(TICK)) djs_sequencer_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .run_in(run_in),
        .jog_in(jog_in), .start_in(start_in), .cstop_in(cstop_in),
        .jog_speed_select_in(sel_in), .zero_speed_in(zero_in),
        .alarm_in(alarm_in), .supply_low_in(low_in), .contactor_out(cont),
        .loops_enable_out(loops), .speed_demand_out(dem));
    djs_plant #(.CST_MIN(50 * TICK)) djs_plant_inst (
        .pclk(pclk), .presetn(presetn), .start_cmd(start_cmd),
        .cstop_cmd(cstop_cmd), .speed_demand(dem), .start_in(start_in),
        .cstop_in(cstop_in), .zero_speed_in(zero_in));

    // 25 MHz clock
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    task automatic close_out;
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                       input string msg);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: %s got %h want %h", $time, msg,
                     seen, exp);
        end
    endtask
    // One APB transfer; request held until pready is seen
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        chk(32'(n < 50), 1, "apb answer");
        if (n >= 50) close_out();
    endtask
    // Bounded wait for the contactor or the demand to reach a value
    task automatic wait_on(input bit on_cont, input logic [15:0] v);
        int n;
        n = 0;
        while ((on_cont ? {15'h0000, cont} : dem) !== v && n < 4000) begin
            @(posedge pclk);
            n++;
        end
        chk(32'(on_cont ? {15'h0000, cont} : dem), 32'(v), "wait value");
        if (n >= 4000) close_out();
    endtask
    task automatic chk_state(input djs_pkg::djs_state_e s);
        apb(1'b0, djs_pkg::OFS_STATUS, 32'h0000_0000);
        chk(32'(rd[22:20]), 32'(s), "state");
    endtask

    // Reset values, write masking and refused accesses
    task automatic t_regs;
        logic [15:0] rst [10];
        rst = '{djs_pkg::RST_RUN_REF, djs_pkg::RST_JOG_SPD1,
                djs_pkg::RST_JOG_SPD2, djs_pkg::RST_SLK_SPD1,
                djs_pkg::RST_SLK_SPD2, djs_pkg::RST_CRAWL_SPD,
                djs_pkg::RST_RUN_STEP, djs_pkg::RST_STOP_STEP,
                djs_pkg::RST_JOG_STEP, djs_pkg::RST_DROP_MS};
        for (int i = 0; i < djs_pkg::NCFG; i++) begin
            apb(1'b0, 8'(i * 4), 32'h0000_0000);
            chk(rd, {16'h0000, rst[i]}, "reset value");
        end
        apb(1'b1, djs_pkg::OFS_RUN_REF, 32'hFFFF_0100);
        apb(1'b0, djs_pkg::OFS_RUN_REF, 32'h0000_0000);
        chk(rd, 32'h0000_0100, "run ref");
        chk(32'(err), 0, "good access");
        apb(1'b1, djs_pkg::OFS_RUN_STEP, 32'h0000_0020);
        apb(1'b1, djs_pkg::OFS_DROP_MS, 32'h0000_0005);
        apb(1'b1, djs_pkg::OFS_STATUS, 32'h0000_FFFF);
        chk(32'(err), 1, "status write");
        apb(1'b0, 8'h2C, 32'h0000_0000);
        chk({rd[30:0], err}, 32'h0000_0001, "unmapped");
    endtask
    // Refused start, run ramp, ramped stop and contactor release
    task automatic t_run;
        alarm_in  <= 1'b1;
        start_cmd <= 1'b1;
        repeat (600) @(posedge pclk);
        chk(32'(cont), 0, "start with alarm");
        start_cmd <= 1'b0;
        repeat (5) @(posedge pclk);
        // Alarm clears only once start has fallen, so no stray start
        alarm_in  <= 1'b0;
        start_cmd <= 1'b1;
        wait_on(1'b0, 16'h0020);
        wait_on(1'b0, 16'h0100);
        chk(32'(loops), 1, "loops on");
        start_cmd <= 1'b0;
        wait_on(1'b0, 16'h00F0);
        wait_on(1'b0, 16'h0000);
        wait_on(1'b1, 16'h0000);
    endtask
    // Jog at both speeds, ramp down and timed contactor hold
    task automatic t_jog;
        int n;
        for (int s = 0; s < 2; s++) begin
            sel_in <= s[0];
            jog_in <= 1'b1;
            wait_on(1'b0, s[0] ? djs_pkg::RST_JOG_SPD2
                                : djs_pkg::RST_JOG_SPD1);
            jog_in <= 1'b0;
            repeat (8) @(posedge pclk);
            chk(32'(dem != 16'h0000 && cont), 1, "jog ramp");
            wait_on(1'b0, 16'h0000);
            n = 0;
            while (cont === 1'b1 && n < 200) begin
                @(posedge pclk);
                n++;
            end
            chk(32'(n >= 40 && n <= 75), 1, "drop delay");
        end
    endtask
    // Crawl from select high; run steps up, stop steps down
    task automatic t_crawl;
        start_cmd <= 1'b1;
        wait_on(1'b0, 16'h0020);
        wait_on(1'b0, djs_pkg::RST_CRAWL_SPD);
        chk_state(djs_pkg::ST_CRAWL);
        start_cmd <= 1'b0;
        sel_in    <= 1'b0;
        wait_on(1'b0, djs_pkg::RST_CRAWL_SPD
                      - djs_pkg::RST_STOP_STEP);
        wait_on(1'b1, 16'h0000);
    endtask
    // Jog while running gives slack take-up
    task automatic t_slack;
        start_cmd <= 1'b1;
        wait_on(1'b0, 16'h0100);
        jog_in <= 1'b1;
        wait_on(1'b0, djs_pkg::RST_SLK_SPD1);
        chk_state(djs_pkg::ST_SLACK);
        jog_in    <= 1'b0;
        start_cmd <= 1'b0;
        wait_on(1'b1, 16'h0000);
    endtask
    // Coast stop while running; run low in the middle of a stop
    task automatic t_trip;
        start_cmd <= 1'b1;
        wait_on(1'b0, 16'h0100);
        cstop_cmd <= 1'b0;
        repeat (8) @(posedge pclk);
        chk(32'({cont, dem}), 0, "coast drop");
        cstop_cmd <= 1'b1;
        wait_on(1'b0, 16'h0100);
        start_cmd <= 1'b0;
        repeat (30) @(posedge pclk);
        run_in <= 1'b0;
        repeat (8) @(posedge pclk);
        chk(32'({cont, loops}), 0, "run low");
        run_in <= 1'b1;
    endtask
    // Supply low gives a ramped shutdown, not a trip
    task automatic t_supply;
        start_cmd <= 1'b1;
        wait_on(1'b0, 16'h0100);
        low_in <= 1'b1;
        repeat (8) @(posedge pclk);
        chk(32'(cont && dem != 16'h0000), 1, "supply ramp");
        wait_on(1'b1, 16'h0000);
        start_cmd <= 1'b0;
        repeat (10) @(posedge pclk);
        low_in <= 1'b0;
    endtask

    initial begin
        n_errors = 0;
        checks = 0;
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {jog_in, start_cmd, sel_in, alarm_in, low_in} = '0;
        run_in = 1'b1;
        cstop_cmd = 1'b1;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_run();
        t_jog();
        t_crawl();
        t_slack();
        t_trip();
        t_supply();
        close_out();
    end
endmodule
